// ---- hdl/ptt_pkg.sv ----
// Package: register map, reset values and field layouts of the timer block
`default_nettype none
package ptt_pkg;
  localparam logic [5:0] PTT_IDX_WIDE_CNT = 6'h00;
  localparam logic [5:0] PTT_IDX_PER_CTRL = 6'h01;
  localparam logic [5:0] PTT_IDX_PER_CNT = 6'h02;
  localparam logic [5:0] PTT_IDX_PER_VAL = 6'h03;
  localparam logic [5:0] PTT_IDX_IRQ_STAT = 6'h04;
  localparam logic [5:0] PTT_IDX_WIDE_CTRL = 6'h05;
  localparam logic [5:0] PTT_IDX_IRQ_MASK = 6'h06;
  localparam logic [7:0] PTT_CTRL_RST = 8'h00;
  localparam logic [7:0] PTT_CTRL_WMASK = 8'hFE;
  localparam logic [4:0] PTT_PCTRL_RST = 5'h00;
  localparam logic [15:0] PTT_CNT_RST = 16'h0000;
  localparam logic [15:0] PTT_WIDE_MAX = 16'hFFFF;
  localparam logic [3:0] PTT_STAT_RST = 4'h0;
  localparam logic [7:0] PTT_PRE_RST = 8'h00;
  localparam int PTT_ST_WIDE = 0;
  localparam int PTT_ST_LOW = 1;
  localparam int PTT_ST_HIGH = 2;
  localparam int PTT_ST_EXTINT = 3;
  typedef struct packed {
    logic extIntEdgeSelect;
    logic extClkEdgeSelect;
    logic clockSourceSelect;
    logic [3:0] prescaleSelect;
    logic unusedBit;
  } ptt_ctrl_t;
  typedef struct packed {
    logic highExtClk;
    logic lowExtClk;
    logic highTimerRun;
    logic lowTimerRun;
    logic cascadeSelect;
  } ptt_pctrl_t;
endpackage
`default_nettype wire

// ---- hdl/ptt_timers.sv ----
// Timer block: prescaled wide overflow counter and two cascadable period timers
`default_nettype none
module ptt_timers
  import ptt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic wideTimerClkPin,
  input wire logic sharedTimerClkPin,
  input wire logic extIntPin
);
  function automatic logic [7:0] preMask(input logic [3:0] code);
    logic [3:0] n;
    logic [8:0] m;
    n = code[3] ? 4'h8 : {1'b0, code[2:0]};
    m = (9'h001 << n) - 9'h001;
    return m[7:0];
  endfunction

  function automatic logic [15:0] wrMerge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  ptt_ctrl_t ctrl_r;
  ptt_pctrl_t pctrl_r;
  logic [15:0] wideCnt_r;
  logic [15:0] perCnt_r;
  logic [15:0] perVal_r;
  logic [3:0] stat_r;
  logic [3:0] stat_nxt;
  logic [3:0] mask_r;
  logic [7:0] pre_r;
  logic pinLvlPrev_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic shPrev_r;
  logic intPrev_r;
  logic ackSent_r;
  logic [5:0] idx;
  logic wrEn;
  logic [31:0] rdData;
  logic pinLvl;
  logic srcEvt;
  logic divLvl;
  logic wideTick;
  logic shEdge;
  logic lowTick;
  logic highTick;
  logic casc16;
  logic lowMatch;
  logic highMatch;
  logic wideWrap;
  logic lowRoll;
  logic highRoll;
  logic extIntEvt;

  // Bus: ack one cycle after request; write lands on the acked edge
  assign idx = wb_adr_i[7:2];
  assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && ackSent_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ackSent_r <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ackSent_r <= wb_cyc_i && wb_stb_i && !ackSent_r;
      wb_dat_o <= rdData;
    end
  end
  assign wb_ack_o = ackSent_r;

  // Unmapped words read zero and swallow writes
  always_comb
  begin
    rdData = 32'h0000_0000;
    if (idx == PTT_IDX_WIDE_CNT)
      rdData[15:0] = wideCnt_r;
    else if (idx == PTT_IDX_PER_CTRL)
      rdData[4:0] = pctrl_r;
    else if (idx == PTT_IDX_PER_CNT)
      rdData[15:0] = perCnt_r;
    else if (idx == PTT_IDX_PER_VAL)
      rdData[15:0] = perVal_r;
    else if (idx == PTT_IDX_IRQ_STAT)
      rdData[3:0] = stat_r;
    else if (idx == PTT_IDX_WIDE_CTRL)
      rdData[7:0] = {ctrl_r[7:1], 1'b0};
    else if (idx == PTT_IDX_IRQ_MASK)
      rdData[3:0] = mask_r;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ctrl_r <= PTT_CTRL_RST;
    else if (wrEn && idx == PTT_IDX_WIDE_CTRL && wb_sel_i[0])
      ctrl_r <= wb_dat_i[7:0] & PTT_CTRL_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pctrl_r <= PTT_PCTRL_RST;
      perVal_r <= PTT_CNT_RST;
      mask_r <= PTT_STAT_RST;
    end
    else if (wrEn)
    begin
      if (idx == PTT_IDX_PER_CTRL && wb_sel_i[0])
        pctrl_r <= wb_dat_i[4:0];
      if (idx == PTT_IDX_PER_VAL)
        perVal_r <= wrMerge(perVal_r, wb_dat_i[15:0], wb_sel_i[1:0]);
      if (idx == PTT_IDX_IRQ_MASK && wb_sel_i[0])
        mask_r <= wb_dat_i[3:0];
    end
  end

  // Wide timer source and prescaler
  always_comb
  begin
    pinLvl = wideTimerClkPin ~^ ctrl_r.extClkEdgeSelect;
    srcEvt = ctrl_r.clockSourceSelect | (pinLvl & ~pinLvlPrev_r);
    if (ctrl_r.prescaleSelect == 4'h0)
      divLvl = pinLvl;
    else if (ctrl_r.prescaleSelect[3])
      divLvl = pre_r[7];
    else
      divLvl = pre_r[ctrl_r.prescaleSelect[2:0] - 3'h1];
    // Internal path needs no synchroniser; pin path only ticks on sync edge
    if (ctrl_r.clockSourceSelect)
      wideTick = &(pre_r | ~preMask(ctrl_r.prescaleSelect));
    else
      wideTick = sync2_r & ~sync3_r;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pre_r <= PTT_PRE_RST;
      // Idle pin level under reset edge select: no false count after reset
      pinLvlPrev_r <= 1'b1;
    end
    else
    begin
      pinLvlPrev_r <= pinLvl;
      if (srcEvt)
        pre_r <= pre_r + 8'h01;
    end
  end

  // Pin is prescaled first, then synchronised; sync1 feeds sync2 only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end
    else
    begin
      sync1_r <= divLvl;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign wideWrap = wideTick && wideCnt_r == PTT_WIDE_MAX;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      wideCnt_r <= PTT_CNT_RST;
    else if (wrEn && idx == PTT_IDX_WIDE_CNT)
      wideCnt_r <= wrMerge(wideCnt_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (wideTick)
      wideCnt_r <= wideCnt_r + 16'h0001;
  end

  // Period timers; shared pin counts on falling edges
  always_comb
  begin
    shEdge = shPrev_r & ~sharedTimerClkPin;
    lowTick = pctrl_r.lowExtClk ? shEdge : 1'b1;
    highTick = pctrl_r.highExtClk ? shEdge : 1'b1;
    casc16 = pctrl_r.cascadeSelect & pctrl_r.lowTimerRun & pctrl_r.highTimerRun;
    lowMatch = casc16 ? (perCnt_r == perVal_r) : (perCnt_r[7:0] == perVal_r[7:0]);
    highMatch = perCnt_r[15:8] == perVal_r[15:8];
    lowRoll = pctrl_r.lowTimerRun && lowTick && lowMatch;
    highRoll = !pctrl_r.cascadeSelect && pctrl_r.highTimerRun && highTick && highMatch;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      perCnt_r <= PTT_CNT_RST;
    else if (wrEn && idx == PTT_IDX_PER_CNT)
      perCnt_r <= wrMerge(perCnt_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (casc16)
    begin
      if (lowTick)
        perCnt_r <= lowMatch ? 16'h0000 : perCnt_r + 16'h0001;
    end
    else
    begin
      // Cascade with only low running: low alone counts
      if (pctrl_r.lowTimerRun && lowTick)
        perCnt_r[7:0] <= lowMatch ? 8'h00 : perCnt_r[7:0] + 8'h01;
      if (highRoll)
        perCnt_r[15:8] <= 8'h00;
      else if (!pctrl_r.cascadeSelect && pctrl_r.highTimerRun && highTick)
        perCnt_r[15:8] <= perCnt_r[15:8] + 8'h01;
    end
  end

  // Flags: set wins over a same-cycle write-one clear
  assign extIntEvt = ctrl_r.extIntEdgeSelect ? (extIntPin & ~intPrev_r)
                                             : (~extIntPin & intPrev_r);

  always_comb
  begin
    stat_nxt = stat_r;
    if (wrEn && idx == PTT_IDX_IRQ_STAT && wb_sel_i[0])
      stat_nxt = stat_r & ~wb_dat_i[3:0];
    stat_nxt[PTT_ST_WIDE] = stat_nxt[PTT_ST_WIDE] | wideWrap;
    stat_nxt[PTT_ST_LOW] = stat_nxt[PTT_ST_LOW] | lowRoll;
    stat_nxt[PTT_ST_HIGH] = stat_nxt[PTT_ST_HIGH] | highRoll;
    stat_nxt[PTT_ST_EXTINT] = stat_nxt[PTT_ST_EXTINT] | extIntEvt;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stat_r <= PTT_STAT_RST;
      irq_o <= 1'b0;
      shPrev_r <= 1'b0;
      intPrev_r <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      irq_o <= |(stat_nxt & mask_r);
      shPrev_r <= sharedTimerClkPin;
      intPrev_r <= extIntPin;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ctrl_bit_zero: assert property (wb_ack_o && idx == PTT_IDX_WIDE_CTRL |-> !wb_dat_o[0])
    else $error("control bit 0 read as one");
  a_ctrl_reset_zero: assert property (disable iff (1'b0) !nrst |=> ctrl_r == 8'h00)
    else $error("control not cleared by reset");
  a_wide_wrap_flag: assert property (wideWrap && !wrEn |=> wideCnt_r == 16'h0000 && stat_r[0])
    else $error("wide wrap missed zero or flag");
  a_int_clk_rate: assert property (ctrl_r.clockSourceSelect && ctrl_r.prescaleSelect == 4'h0
      && !wrEn |=> wideCnt_r == $past(wideCnt_r) + 16'h0001)
    else $error("internal clock did not count each cycle");
  a_pre_256_gap: assert property (wideTick && ctrl_r.clockSourceSelect
      && ctrl_r.prescaleSelect[3] && !wrEn
      |=> (!wideTick || !ctrl_r.clockSourceSelect || !ctrl_r.prescaleSelect[3]) [*8])
    else $error("prescale 256 ticked too soon");
  a_ext_sync_delay: assert property (!ctrl_r.clockSourceSelect && ctrl_r.prescaleSelect == 4'h0
      && $rose(divLvl) |-> ##1 !wideTick ##1 wideTick)
    else $error("external tick not two cycles after edge");
  a_low_roll_flag: assert property (!pctrl_r.cascadeSelect && lowRoll && !wrEn
      |=> perCnt_r[7:0] == 8'h00 && stat_r[1])
    else $error("low timer roll wrong");
  a_casc_roll_flag: assert property (casc16 && lowRoll && !wrEn
      |=> perCnt_r == 16'h0000 && stat_r[1])
    else $error("cascaded roll wrong");
  a_casc_needs_both: assert property (pctrl_r.cascadeSelect && !pctrl_r.lowTimerRun && !wrEn
      |=> $stable(perCnt_r))
    else $error("cascade counted with low stopped");
  a_high_roll_flag: assert property (highRoll |=> stat_r[2])
    else $error("high flag not set");
  a_int_edge_flag: assert property (ctrl_r.extIntEdgeSelect && $rose(extIntPin) |=> stat_r[3])
    else $error("rising external interrupt missed");

  c_wide_wrap: cover property (wideWrap);
  c_casc_roll: cover property (casc16 && lowRoll);
  c_irq_raise: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ---- verification/ptt_pin_model.sv ----
// Far-side model: external timer clock pins and interrupt pin
`default_nettype none
module ptt_pin_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] togReq,
  output logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // One request flips one pin; spacing kept by the caller
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pins <= 3'h0;
    else
      pins <= pins ^ togReq;
  end
endmodule
`default_nettype wire

// ---- verification/ptt_timers_tb.sv ----
// Bench: register-level tests of the timer block
`default_nettype none
module ptt_timers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [2:0] togReq, pins;
  logic [15:0] v, a;
  logic [3:0] ps;
  int err_count, checks, div;

  ptt_timers dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wideTimerClkPin(pins[0]),
    .sharedTimerClkPin(pins[1]), .extIntPin(pins[2]));
  ptt_pin_model pin_u (.clk(clk), .nrst(nrst), .togReq(togReq), .pins(pins));

  task results;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] ad, input logic [15:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {16'h0000, d};
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk);
    v = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      results;
    end
  endtask

  task chk(input logic [15:0] exp);
    checks++;
    if (v !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, v, exp);
    end
  endtask

  task wr(input logic [7:0] ad, input logic [15:0] d);
    bus(1'b1, ad, d);
  endtask

  task rd(input logic [7:0] ad, input logic [15:0] m, input logic [15:0] exp);
    bus(1'b0, ad, 16'h0000);
    v = v & m;
    chk(exp);
  endtask

  task irqChk(input logic exp);
    repeat (2) @(posedge clk);
    v = {15'h0000, irq};
    chk({15'h0000, exp});
  endtask

  // Long gap so the two-flop sync path settles before a read
  task tog(input int i);
    @(posedge clk);
    togReq[i] <= 1'b1;
    @(posedge clk);
    togReq[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    togReq = 3'h0;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h14, 16'hFFFF, 16'h0000);
    rd(8'h00, 16'hFFFF, 16'h0000);
    wr(8'h14, 16'h00FF);
    rd(8'h14, 16'hFFFF, 16'h00FE);
    rd(8'h1C, 16'hFFFF, 16'h0000);
    // Prescaler is not cleared on writes, so allow one count of slack
    for (int c = 0; c < 10; c++)
    begin
      ps = (c == 9) ? 4'hF : c[3:0];
      div = ps[3] ? 256 : (1 << ps);
      wr(8'h14, {10'h000, 1'b1, ps, 1'b0});
      bus(1'b0, 8'h00, 16'h0000);
      a = v;
      repeat (8 * div - 3) @(posedge clk);
      bus(1'b0, 8'h00, 16'h0000);
      v = v - a;
      v = (v >= 16'h0007 && v <= 16'h0009) ? 16'h0001 : v;
      chk(16'h0001);
    end
    wr(8'h10, 16'h000F);
    wr(8'h14, 16'h0020);
    wr(8'h00, 16'hFFF0);
    repeat (30) @(posedge clk);
    rd(8'h10, 16'h0001, 16'h0001);
    rd(8'h00, 16'hFF00, 16'h0000);
    irqChk(1'b0);
    wr(8'h18, 16'h0001);
    irqChk(1'b1);
    wr(8'h14, 16'h0000);
    wr(8'h10, 16'h0001);
    irqChk(1'b0);
    wr(8'h18, 16'h0000);
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h14, e ? 16'h0040 : 16'h0000);
      wr(8'h00, 16'h0000);
      tog(0);
      rd(8'h00, 16'hFFFF, 16'(e));
      tog(0);
      rd(8'h00, 16'hFFFF, 16'h0001);
    end
    wr(8'h14, 16'h0002);
    // Edge-select change may leave one tick in flight
    repeat (6) @(posedge clk);
    wr(8'h00, 16'h0000);
    repeat (8) tog(0);
    rd(8'h00, 16'hFFFF, 16'h0002);
    wr(8'h18, 16'h0008);
    wr(8'h14, 16'h0080);
    wr(8'h10, 16'h000F);
    tog(2);
    rd(8'h10, 16'h0008, 16'h0008);
    irqChk(1'b1);
    wr(8'h10, 16'h0008);
    tog(2);
    rd(8'h10, 16'h0008, 16'h0000);
    wr(8'h14, 16'h0000);
    tog(2);
    rd(8'h10, 16'h0008, 16'h0000);
    tog(2);
    rd(8'h10, 16'h0008, 16'h0008);
    wr(8'h18, 16'h0000);
    wr(8'h0C, 16'h0503);
    wr(8'h08, 16'h0000);
    wr(8'h10, 16'h000F);
    wr(8'h04, 16'h0002);
    repeat (20) @(posedge clk);
    rd(8'h10, 16'h0006, 16'h0002);
    rd(8'h08, 16'hFFFC, 16'h0000);
    wr(8'h04, 16'h0004);
    wr(8'h10, 16'h000F);
    repeat (20) @(posedge clk);
    rd(8'h10, 16'h0006, 16'h0004);
    rd(8'h08, 16'hF8FC, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h08, 16'h0000);
    wr(8'h10, 16'h000F);
    wr(8'h04, 16'h0007);
    repeat (1150) @(posedge clk);
    rd(8'h10, 16'h0006, 16'h0000);
    repeat (200) @(posedge clk);
    rd(8'h10, 16'h0006, 16'h0002);
    rd(8'h08, 16'hFF00, 16'h0000);
    wr(8'h04, 16'h0003);
    wr(8'h08, 16'h0200);
    wr(8'h10, 16'h000F);
    repeat (20) @(posedge clk);
    rd(8'h10, 16'h0006, 16'h0002);
    rd(8'h08, 16'hFF00, 16'h0200);
    wr(8'h04, 16'h001E);
    wr(8'h08, 16'h0000);
    wr(8'h0C, 16'hFFFF);
    repeat (6) tog(1);
    rd(8'h08, 16'hFFFF, 16'h0303);
    results;
  end
endmodule
`default_nettype wire
